// ### sim/cgo_channel_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cgo_channel_ctrl_properties
    import cgo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire cgo_sample_t ch1_raw_i,
    input wire cgo_sample_t ch2_raw_i,
    input wire cgo_sample_t ch1_out_o,
    input wire cgo_sample_t ch2_out_o,
    input wire logic [2:0] ch1_gain_exp_o,
    input wire logic [2:0] ch2_gain_exp_o,
    input wire logic [1:0] ch1_range_o,
    input wire logic [2:0] ch1_fs_shift_o,
    input wire logic ch1_integ_en_o,
    input wire logic ch1_hpf_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ch1_gain_max: assert property (ch1_gain_exp_o <= CGO_GAIN_MAX)
        else $error("ch1 gain exponent out of range");
    a_ch2_gain_max: assert property (ch2_gain_exp_o <= CGO_GAIN_MAX)
        else $error("ch2 gain exponent out of range");
    a_range_max: assert property (ch1_range_o <= CGO_RANGE_MAX)
        else $error("ch1 range code out of range");
    a_fs_shift_sum: assert property (ch1_fs_shift_o == ((ch1_range_o + ch1_gain_exp_o > 6) ? 6 :
        ch1_range_o + ch1_gain_exp_o)) else $error("full scale shift not range plus gain");
    a_ch1_out_delay: assert property (ch1_raw_i.valid |-> ##2 ch1_out_o.valid)
        else $error("ch1 corrected sample missing");
    a_ch2_out_delay: assert property (ch2_raw_i.valid |-> ##2 ch2_out_o.valid)
        else $error("ch2 corrected sample missing");
    a_out_has_cause: assert property (ch1_out_o.valid |-> $past(ch1_raw_i.valid, 2))
        else $error("ch1 sample without raw input");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read not answered next cycle");
    a_integ_off: assert property ($past(rst_i) |-> !ch1_integ_en_o)
        else $error("integrator on after reset");
    cover property (ch1_integ_en_o);
    cover property (ch1_fs_shift_o == 3'h6);
    cover property (ch1_out_o.valid && ch1_hpf_en_o);
endmodule // cgo_channel_ctrl_properties
bind cgo_channel_ctrl cgo_channel_ctrl_properties u_cgo_channel_ctrl_properties (.*);
`default_nettype wire

// ### sim/cgo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cgo_host_model (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
    // host writes trims through this path
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= s;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        // Each channel released right after the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            if (!aw_done && awready_i) begin
                awvalid_o <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && wready_i) begin
                wvalid_o <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (!bvalid_i) @(posedge clk_i);
        bready_o <= 1'b0;
        // Gap so a following call never drives valid twice in one step
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        while (!rvalid_i) @(posedge clk_i);
        if (!rvalid_i || arvalid_o) @(posedge clk_i);
        rready_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // cgo_host_model
`default_nettype wire

// ### sim/channel_gain_offset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module channel_gain_offset_control_tb;
    import cgo_pkg::*;
    logic clk_i = 0, rst_i = 1;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, integ, hpf;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rng;
    logic [2:0] g1e, g2e, fs;
    cgo_sample_t r1 = '0, r2 = '0, o1, o2;
    int error_cnt = 0, cmp_count = 0, seed = 42, t1, t2, g, hp = 0, last1, last2, e1, er;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    logic signed [23:0] q1[$], q2[$];
    initial forever #2.5 clk_i = ~clk_i;
    cgo_channel_ctrl u_cgo_channel_ctrl (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .ch1_raw_i(r1), .ch2_raw_i(r2), .ch1_out_o(o1), .ch2_out_o(o2),
        .ch1_gain_exp_o(g1e), .ch2_gain_exp_o(g2e), .ch1_range_o(rng), .ch1_fs_shift_o(fs),
        .ch1_integ_en_o(integ), .ch1_hpf_en_o(hpf));
    cgo_host_model u_cgo_host_model (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bvalid_i(bvalid),
        .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rvalid_i(rvalid),
        .rready_o(rready));
    task chk(input logic [33:0] s, input logic [33:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        wq.push_back(e);
        u_cgo_host_model.wr(a, d, s);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        u_cgo_host_model.rd(a);
    endtask
    // Trim in output codes; sign bit set means a negative trim
    function automatic int tv(int t, int gg);
        tv = int'((t & 31) * CGO_STEP_WT[gg]) << gg;
        if (t[5]) tv = -tv;
    endfunction
    task automatic smp(input int d1, input int d2);
        r1 <= {1'b1, d1[23:0]};
        r2 <= {1'b1, d2[23:0]};
        last1 = d1 - tv(t1, g);
        last2 = d2 - tv(t2, g);
        if (hp == 0) q1.push_back(24'(last1));
        q2.push_back(24'(last2));
        // Valid stays up so back-to-back samples never drive it twice in one step
        @(posedge clk_i);
    endtask
    task automatic idle;
        r1.valid <= 1'b0;
        r2.valid <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk(34'(bresp), 34'(wq.pop_front()));
        if (o1.valid && hp == 0) chk(34'(o1.data), 34'(q1.pop_front()));
        if (o2.valid) chk(34'(o2.data), 34'(q2.pop_front()));
    end
    initial begin
        #200us;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(34'(integ), 34'h0);
        for (int a = 0; a < 16; a += 4) rreg(8'(a), {CGO_RESP_OKAY, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wreg(CGO_ADDR_GAIN, 32'({i[2:0], i[1:0], ~i[2:0]}), 4'h1, CGO_RESP_OKAY);
            e1 = (7 - i > 4) ? 4 : 7 - i;
            er = ((i & 3) > 2) ? 2 : (i & 3);
            chk(34'(g1e), 34'(e1));
            chk(34'(g2e), 34'((i > 4) ? 4 : i));
            chk(34'(rng), 34'(er));
            chk(34'(fs), 34'((e1 + er > 6) ? 6 : e1 + er));
            rreg(CGO_ADDR_GAIN, {CGO_RESP_OKAY, 24'h0, i[2:0], i[1:0], ~i[2:0]});
        end
        $display("test gain codes done");
        for (g = 0; g < 5; g++) begin
            t1 = (g == 0) ? 31 : $random(seed) & 63;
            t2 = (g == 0) ? 63 : $random(seed) & 63;
            wreg(CGO_ADDR_GAIN, 32'(g * 33), 4'h1, CGO_RESP_OKAY);
            wreg(CGO_ADDR_TRIM1, 32'(t1), 4'h1, CGO_RESP_OKAY);
            wreg(CGO_ADDR_TRIM2, 32'(t2), 4'hf, CGO_RESP_OKAY);
            chk(34'(integ | hpf), 34'h0);
            smp($random(seed) % 1048576, $random(seed) % 1048576);
            smp($random(seed) % 1048576, $random(seed) % 1048576);
            idle();
            repeat (3) @(posedge clk_i);
            rreg(CGO_ADDR_WAVE1, {CGO_RESP_OKAY, 32'(last1)});
            rreg(CGO_ADDR_WAVE2, {CGO_RESP_OKAY, 32'(last2)});
        end
        $display("test trims done");
        wreg(CGO_ADDR_TRIM1, 32'hff, 4'h1, CGO_RESP_OKAY);
        chk(34'(integ), 34'h1);
        wreg(CGO_ADDR_TRIM1, 32'h0, 4'he, CGO_RESP_OKAY);
        rreg(CGO_ADDR_TRIM1, {CGO_RESP_OKAY, 32'hbf});
        wreg(8'h20, 32'h1, 4'h1, CGO_RESP_SLVERR);
        wreg(CGO_ADDR_WAVE1, 32'h0, 4'h1, CGO_RESP_SLVERR);
        rreg(8'h20, {CGO_RESP_SLVERR, 32'h0});
        $display("test integrator and refusals done");
        wreg(CGO_ADDR_TRIM1, 32'h0, 4'h1, CGO_RESP_OKAY);
        wreg(CGO_ADDR_CTRL, 32'h1, 4'h1, CGO_RESP_OKAY);
        chk(34'(hpf), 34'h1);
        // Loop left the index one past the last gain actually written
        g = 4;
        t1 = 0;
        hp = 1;
        // Filter time constant is about 1024 samples, so run several
        repeat (8000) smp(4000, 0);
        idle();
        repeat (3) @(posedge clk_i);
        chk(34'(o1.data > -24'sd64 && o1.data < 24'sd64), 34'h1);
        $display("test high-pass done");
        final_report();
    end
endmodule // channel_gain_offset_control_tb
`default_nettype wire

// ### verilog/cgo_channel_ctrl.sv
// Notes on behaviour
// R1: Channel 1 gain code comes from gain register bits 2 to 0.
// R2: Each gain field selects one of gains 1, 2, 4, 8, 16.
// R3: Channel 2 gain code comes from gain register bits 7 to 5.
// R4: Bits 4 and 3 pick channel 1 range 0.5, 0.25 or 0.125 V.
// R5: Channel 1 full scale is range over gain, smallest 0.00781 V.
// R6: Per-channel 6-bit sign-magnitude trim is subtracted from the digitised signal.
// R7: Trim magnitude spans at most 31 steps either way.
// R8: Trim step weight follows gain, 1.61 mV at one to 0.77 mV.
// R9: Waveform read-back shows residual offset when inputs are grounded.
// R10: Host cancels offset by writing the opposite trim, then re-reads.
// R11: Host should disable integrator and high-pass before channel 1 trim.
// R12: Enabled channel 1 high-pass filter removes DC offset.
// R13: Trim 1 register MSB enables the channel 1 integrator.
// R14: Channel 1 integrator is off after reset until software enables it.
// R15: Gain codes 0 to 4 are exponents; range codes 0 to 2.
// R16: Invalid codes clamp to nearest valid; fields clear at reset.
`timescale 1ns/1ps
`default_nettype none
module cgo_channel_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [cgo_pkg::CGO_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [cgo_pkg::CGO_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire cgo_pkg::cgo_sample_t ch1_raw_i,
    input wire cgo_pkg::cgo_sample_t ch2_raw_i,
    output cgo_pkg::cgo_sample_t ch1_out_o,
    output cgo_pkg::cgo_sample_t ch2_out_o,
    output logic [2:0] ch1_gain_exp_o,
    output logic [2:0] ch2_gain_exp_o,
    output logic [1:0] ch1_range_o,
    output logic [2:0] ch1_fs_shift_o,
    output logic ch1_integ_en_o,
    output logic ch1_hpf_en_o
);
    import cgo_pkg::*;

    logic [7:0] gain_q;
    logic [7:0] trim1_q;
    logic [5:0] trim2_q;
    logic [7:0] ctrl_q;
    logic signed [CGO_SAMP_W-1:0] wave1_q;
    logic signed [CGO_SAMP_W-1:0] wave2_q;

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_have_q;
    logic w_have_q;
    logic [CGO_ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_fire;
    logic wr_hit;
    logic [2:0] g1_exp;
    logic [2:0] g2_exp;
    logic [1:0] rng;

    // R15: gain codes are exponents; R16: out-of-range codes clamp
    always_comb begin
        g1_exp = gain_q[CGO_G1_LSB +: 3];
        g2_exp = gain_q[CGO_G2_LSB +: 3];
        rng = gain_q[CGO_RNG_LSB +: 2];
        // R2: only five gains reachable
        if (g1_exp > CGO_GAIN_MAX) begin
            g1_exp = CGO_GAIN_MAX;
        end
        if (g2_exp > CGO_GAIN_MAX) begin
            g2_exp = CGO_GAIN_MAX;
        end
        if (rng > CGO_RANGE_MAX) begin
            rng = CGO_RANGE_MAX;
        end
    end

    // Write channel: address and data accepted in either order
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    always_comb begin
        unique case (awaddr_q)
            CGO_ADDR_GAIN, CGO_ADDR_TRIM1, CGO_ADDR_TRIM2, CGO_ADDR_CTRL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid_i && awready_q) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready_i) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid_i && wready_q) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            wbyte_q <= s_axi_wdata_i[7:0];
            wlane_q <= s_axi_wstrb_i[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready_i) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= CGO_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? CGO_RESP_OKAY : CGO_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // Control registers; R16: clear at reset, R14: integrator off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_q <= CGO_GAIN_RST;
            trim1_q <= CGO_TRIM_RST;
            trim2_q <= CGO_TRIM_RST[5:0];
            ctrl_q <= CGO_CTRL_RST;
        end else if (wr_fire && wlane_q) begin
            unique case (awaddr_q)
                CGO_ADDR_GAIN: gain_q <= wbyte_q;
                // Bit 6 is reserved and held at zero
                CGO_ADDR_TRIM1: trim1_q <= {wbyte_q[CGO_INTEG_BIT], 1'b0, wbyte_q[5:0]};
                CGO_ADDR_TRIM2: trim2_q <= wbyte_q[5:0];
                CGO_ADDR_CTRL: ctrl_q <= {7'h00, wbyte_q[CGO_HPF_BIT]};
                default: ;
            endcase
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= CGO_RESP_OKAY;
        end else if (s_axi_arvalid_i && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= CGO_RESP_OKAY;
            unique case (s_axi_araddr_i)
                CGO_ADDR_GAIN: rdata_q <= {24'h000000, gain_q};
                CGO_ADDR_TRIM1: rdata_q <= {24'h000000, trim1_q};
                CGO_ADDR_TRIM2: rdata_q <= {26'h0, trim2_q};
                CGO_ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
                // R9: waveform read-back, sign-extended
                CGO_ADDR_WAVE1: rdata_q <= {{8{wave1_q[CGO_SAMP_W-1]}}, wave1_q};
                CGO_ADDR_WAVE2: rdata_q <= {{8{wave2_q[CGO_SAMP_W-1]}}, wave2_q};
                default: begin
                    rdata_q <= '0;
                    rresp_q <= CGO_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Offset trim per channel
    logic signed [CGO_SAMP_W-1:0] trim_val [2];
    logic signed [CGO_SAMP_W-1:0] corr_q [2];
    logic corr_vld_q [2];
    logic signed [CGO_SAMP_W:0] diff [2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_trim
            logic [5:0] code;
            logic [2:0] gexp;
            logic [16:0] step;
            cgo_sample_t raw;
            assign code = (ch == 0) ? trim1_q[5:0] : trim2_q;
            assign gexp = (ch == 0) ? g1_exp : g2_exp;
            assign raw = (ch == 0) ? ch1_raw_i : ch2_raw_i;
            // R7: five magnitude bits cap the trim at 31 steps
            // R8: step weight scaled by gain, referred to the output
            assign step = 17'((CGO_TRIM_MAG_W'(code[CGO_TRIM_MAG_W-1:0]) * CGO_STEP_WT[gexp]) << gexp);
            assign trim_val[ch] = code[CGO_TRIM_SIGN] ? -CGO_SAMP_W'(step) : CGO_SAMP_W'(step);
            // R6: subtract the sign-magnitude trim from the sample
            assign diff[ch] = {raw.data[CGO_SAMP_W-1], raw.data} - {trim_val[ch][CGO_SAMP_W-1], trim_val[ch]};

            // Saturate rather than wrap near full scale
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    corr_q[ch] <= '0;
                    corr_vld_q[ch] <= 1'b0;
                end else begin
                    corr_vld_q[ch] <= raw.valid;
                    if (raw.valid) begin
                        if (diff[ch][CGO_SAMP_W] != diff[ch][CGO_SAMP_W-1]) begin
                            corr_q[ch] <= diff[ch][CGO_SAMP_W] ? {1'b1, {(CGO_SAMP_W-1){1'b0}}}
                                                               : {1'b0, {(CGO_SAMP_W-1){1'b1}}};
                        end else begin
                            corr_q[ch] <= diff[ch][CGO_SAMP_W-1:0];
                        end
                    end
                end
            end
        end
    endgenerate

    // R12: first-order DC tracker on channel 1; one-pole trades settling time for ripple
    logic signed [CGO_SAMP_W+CGO_HPF_SHIFT-1:0] dc_acc_q;
    logic signed [CGO_SAMP_W-1:0] dc_est;
    logic signed [CGO_SAMP_W-1:0] ch1_hp;
    assign dc_est = dc_acc_q[CGO_SAMP_W+CGO_HPF_SHIFT-1:CGO_HPF_SHIFT];
    assign ch1_hp = corr_q[0] - dc_est;

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_q[CGO_HPF_BIT]) begin
            dc_acc_q <= '0;
        end else if (corr_vld_q[0]) begin
            dc_acc_q <= dc_acc_q + (CGO_SAMP_W+CGO_HPF_SHIFT)'(ch1_hp);
        end
    end

    // Output samples and waveform registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch1_out_o <= '0;
            ch2_out_o <= '0;
            wave1_q <= '0;
            wave2_q <= '0;
        end else begin
            ch1_out_o.valid <= corr_vld_q[0];
            ch2_out_o.valid <= corr_vld_q[1];
            if (corr_vld_q[0]) begin
                // R12: DC removed only while the filter is on
                ch1_out_o.data <= ctrl_q[CGO_HPF_BIT] ? ch1_hp : corr_q[0];
                // R9: residual offset visible with filter off
                wave1_q <= ctrl_q[CGO_HPF_BIT] ? ch1_hp : corr_q[0];
            end
            if (corr_vld_q[1]) begin
                ch2_out_o.data <= corr_q[1];
                wave2_q <= corr_q[1];
            end
        end
    end

    // Decoded settings to the analog front end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch1_gain_exp_o <= '0;
            ch2_gain_exp_o <= '0;
            ch1_range_o <= '0;
            ch1_fs_shift_o <= '0;
            ch1_integ_en_o <= 1'b0;
            ch1_hpf_en_o <= 1'b0;
        end else begin
            // R1: channel 1 gain
            ch1_gain_exp_o <= g1_exp;
            // R3: channel 2 gain
            ch2_gain_exp_o <= g2_exp;
            // R4: range scales the converter reference
            ch1_range_o <= rng;
            // R5: full scale = 0.5 V >> (range + gain), capped at 0.00781 V
            ch1_fs_shift_o <= (3'(rng) + g1_exp > CGO_FS_SHIFT_MAX) ? CGO_FS_SHIFT_MAX : 3'(rng) + g1_exp;
            // R13: trim 1 MSB turns on the integrator
            ch1_integ_en_o <= trim1_q[CGO_INTEG_BIT];
            ch1_hpf_en_o <= ctrl_q[CGO_HPF_BIT];
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
endmodule // cgo_channel_ctrl
`default_nettype wire

// ### verilog/cgo_pkg.sv
`default_nettype none
package cgo_pkg;
    // Register byte addresses
    localparam logic [7:0] CGO_ADDR_GAIN = 8'h00;
    localparam logic [7:0] CGO_ADDR_TRIM1 = 8'h04;
    localparam logic [7:0] CGO_ADDR_TRIM2 = 8'h08;
    localparam logic [7:0] CGO_ADDR_CTRL = 8'h0c;
    localparam logic [7:0] CGO_ADDR_WAVE1 = 8'h10;
    localparam logic [7:0] CGO_ADDR_WAVE2 = 8'h14;
    localparam int CGO_ADDR_W = 8;

    // Gain register fields
    localparam int CGO_G1_LSB = 0;
    localparam int CGO_RNG_LSB = 3;
    localparam int CGO_G2_LSB = 5;
    localparam logic [2:0] CGO_GAIN_MAX = 3'h4;
    localparam logic [1:0] CGO_RANGE_MAX = 2'h2;

    // Offset trim fields: bit 5 sign, bits 4:0 magnitude
    localparam int CGO_TRIM_SIGN = 5;
    localparam int CGO_TRIM_MAG_W = 5;
    localparam int CGO_INTEG_BIT = 7;
    localparam int CGO_HPF_BIT = 0;

    localparam logic [7:0] CGO_GAIN_RST = 8'h00;
    localparam logic [7:0] CGO_TRIM_RST = 8'h00;
    localparam logic [7:0] CGO_CTRL_RST = 8'h00;

    // Trim step weight at each gain code, in units of 10 uV at the input
    localparam logic [4:0][7:0] CGO_STEP_WT = {8'h4d, 8'h54, 8'h61, 8'h77, 8'ha1};

    // Largest full-scale shift: 0.5 V >> 6 = 0.00781 V
    localparam logic [2:0] CGO_FS_SHIFT_MAX = 3'h6;
    localparam int CGO_HPF_SHIFT = 10;

    localparam int CGO_SAMP_W = 24;
    localparam logic [1:0] CGO_RESP_OKAY = 2'h0;
    localparam logic [1:0] CGO_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic signed [CGO_SAMP_W-1:0] data;
    } cgo_sample_t;
endpackage
`default_nettype wire
